//--- src/ets_consts.vh
// Contract
// RULE_01: exactly one of eight steps is current and only its indicator is lit.
// RULE_02: the upper selector sends its step to trigger row 1 when up, none when centred, row 2 when down.
// RULE_03: the lower selector sends its step to trigger row 3 when up, none when centred, gate row 4 when down.
// RULE_04: each trigger row gives one short pulse when a step routed to it becomes active.
// RULE_05: the gate row stays high for as long as a step routed to it is the active step.
// RULE_06: four row indicators each light while the current step is routed to their row.
// RULE_07: slewing is applied while the slew-enable input is low, otherwise the output jumps at once.
// RULE_08: each of start, stop, step and reset is taken from its button or its input socket.
// RULE_09: a start command puts the sequencer into the running state.
// RULE_10: a stop command leaves the running state and keeps the current step.
// RULE_11: each step-button press counts as exactly one clock pulse and advances one step.
// RULE_12: a reset command returns the sequence to step one, from which advancing continues.
// RULE_13: start and stop act on rising edges only, one event per edge whatever the pulse length.
// RULE_14: reset is level-sensitive and holds step one while it is high.
// RULE_15: an unconnected slew-enable input reads as low, so slewing is on by default.
// RULE_16: advancing from the eighth step wraps to step one.
// RULE_17: while running, each rising edge of the step clock input advances one step.
`ifndef ETS_CONSTS_VH
`define ETS_CONSTS_VH
`define ETS_NUM_STEPS 8
`define ETS_STEP_W 3
`define ETS_STEP_FIRST 3'h0
`define ETS_STEP_LAST 3'h7
`define ETS_SEL_W 2
`define ETS_SEL_CENTRE 2'h0
`define ETS_SEL_UP 2'h1
`define ETS_SEL_DOWN 2'h2
`define ETS_ROW_T1 0
`define ETS_ROW_T2 1
`define ETS_ROW_T3 2
`define ETS_ROW_GATE 3
`define ETS_NUM_ROWS 4
`define ETS_TRIG_PULSE_NS 1000
`define ETS_CLK_NS 8
`endif

//--- src/ets_edge.v
`timescale 1ns/1ps
module ets_edge (
  clock, // system clock
  rst, // async reset
  level, // input level
  rise // one-cycle pulse on rising edge
);
  input wire clock;
  input wire rst;
  input wire level;
  output wire rise;
  reg level_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      level_q <= 1'b0;
    end else begin
      level_q <= level;
    end
  end
  assign rise = level & ~level_q;
endmodule

//--- src/ets_sequencer.v
`timescale 1ns/1ps
`include "ets_consts.vh"
module ets_sequencer #(
  parameter NUM_STEPS = `ETS_NUM_STEPS,
  parameter TRIG_PULSE_NS = `ETS_TRIG_PULSE_NS
) (
  input wire clock, // system clock, 125 MHz
  input wire rst, // async reset, active high
  input wire btn_start, // start push-button
  input wire btn_stop, // stop push-button
  input wire btn_step, // step push-button
  input wire btn_reset, // reset push-button
  input wire jack_start, // start socket
  input wire jack_stop, // stop socket
  input wire jack_step, // step clock socket
  input wire jack_reset, // reset socket
  input wire [2*NUM_STEPS-1:0] sel_upper, // upper selector per step
  input wire [2*NUM_STEPS-1:0] sel_lower, // lower selector per step
  input wire slew_ctrl, // slew-enable control, low = slew
  input wire slew_ctrl_present, // high when a plug is in the slew socket
  output reg [NUM_STEPS-1:0] step_led, // step indicators, one-hot
  output reg [2:0] trig_out, // trigger rows 1..3
  output reg gate_out, // gate row
  output reg [3:0] row_led, // row-activity indicators
  output reg slew_en, // slewing applied to processed output
  output reg running, // running state
  output reg [`ETS_STEP_W-1:0] step_idx // current step, 0 = step one
);
  localparam ST_STOP = 2'b01;
  localparam ST_RUN = 2'b10;
  localparam integer PULSE_CYC_I = (TRIG_PULSE_NS + `ETS_CLK_NS - 1) / `ETS_CLK_NS;
  localparam [15:0] PULSE_CYC = PULSE_CYC_I[15:0];

  function [`ETS_NUM_ROWS-1:0] route;
    input [1:0] up;
    input [1:0] lo;
    begin
      route = {`ETS_NUM_ROWS{1'b0}};
      route[`ETS_ROW_T1] = (up == `ETS_SEL_UP); // [RULE_02]
      route[`ETS_ROW_T2] = (up == `ETS_SEL_DOWN); // [RULE_02]
      route[`ETS_ROW_T3] = (lo == `ETS_SEL_UP); // [RULE_03]
      route[`ETS_ROW_GATE] = (lo == `ETS_SEL_DOWN); // [RULE_03]
    end
  endfunction

  wire start_rise;
  wire stop_rise;
  wire step_rise;
  wire reset_lvl;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`ETS_STEP_W-1:0] step_d;
  reg [15:0] pulse_cnt_q;
  reg [3:0] cur_rows;
  wire advance;

  ets_edge u_start (
    .clock(clock),
    .rst(rst),
    .level(btn_start | jack_start), // [RULE_08]
    .rise(start_rise) // [RULE_13]
  );
  ets_edge u_stop (
    .clock(clock),
    .rst(rst),
    .level(btn_stop | jack_stop), // [RULE_08]
    .rise(stop_rise) // [RULE_13]
  );
  ets_edge u_step (
    .clock(clock),
    .rst(rst),
    .level(btn_step | jack_step), // [RULE_08]
    .rise(step_rise)
  );
  assign reset_lvl = btn_reset | jack_reset; // [RULE_08]

  // button step works stopped too; socket clock only while running
  assign advance = step_rise & ((state_q == ST_RUN) | btn_step); // [RULE_11] [RULE_17]

  always @* begin
    case (state_q)
      ST_STOP: state_d = start_rise ? ST_RUN : ST_STOP; // [RULE_09]
      ST_RUN: state_d = stop_rise ? ST_STOP : ST_RUN; // [RULE_10]
      default: state_d = ST_STOP;
    endcase
  end

  always @* begin
    if (reset_lvl) begin
      step_d = `ETS_STEP_FIRST; // [RULE_12] [RULE_14]
    end else if (advance) begin
      if (step_idx == NUM_STEPS - 1) begin
        step_d = `ETS_STEP_FIRST; // [RULE_16]
      end else begin
        step_d = step_idx + 1'b1;
      end
    end else begin
      step_d = step_idx; // [RULE_10]
    end
  end

  always @* begin
    cur_rows = route(sel_upper[2*step_d +: 2], sel_lower[2*step_d +: 2]);
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_STOP;
      step_idx <= `ETS_STEP_FIRST;
      pulse_cnt_q <= 16'h0000;
      step_led <= {{(NUM_STEPS-1){1'b0}}, 1'b1};
      trig_out <= 3'h0;
      gate_out <= 1'b0;
      row_led <= 4'h0;
      slew_en <= 1'b1;
      running <= 1'b0;
    end else begin
      state_q <= state_d;
      running <= (state_d == ST_RUN);
      step_idx <= step_d;
      step_led <= {{(NUM_STEPS-1){1'b0}}, 1'b1} << step_d; // [RULE_01]
      row_led <= cur_rows; // [RULE_06]
      gate_out <= cur_rows[`ETS_ROW_GATE]; // [RULE_05]
      slew_en <= ~(slew_ctrl & slew_ctrl_present); // [RULE_07] [RULE_15]
      if (step_d != step_idx || (advance && NUM_STEPS == 1)) begin
        trig_out <= cur_rows[2:0]; // [RULE_04]
        pulse_cnt_q <= PULSE_CYC;
      end else if (pulse_cnt_q > 16'h0001) begin
        pulse_cnt_q <= pulse_cnt_q - 16'h0001;
      end else begin
        pulse_cnt_q <= 16'h0000;
        trig_out <= 3'h0; // [RULE_04]
      end
    end
  end
endmodule

//--- verification/ets_seq_asserts.sv
`timescale 1ns/1ps
module ets_seq_asserts #(parameter NUM_STEPS = 8) (
  input wire clock, rst, btn_start, btn_stop, btn_step, btn_reset, // clock, buttons
  input wire jack_start, jack_stop, jack_step, jack_reset, // sockets
  input wire slew_ctrl, slew_ctrl_present, gate_out, slew_en, running, // levels
  input wire [2*NUM_STEPS-1:0] sel_upper, sel_lower, // selectors
  input wire [NUM_STEPS-1:0] step_led, // step lamps
  input wire [2:0] trig_out, step_idx, // triggers, step
  input wire [3:0] row_led // row lamps
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire clr = btn_reset | jack_reset;
  wire [1:0] up = sel_upper[2*step_idx+:2];
  wire [1:0] lo = sel_lower[2*step_idx+:2];
  sequence held;
    ($stable(step_idx) && $stable(sel_upper) && $stable(sel_lower)) [*2];
  endsequence
  a_led_one_hot: assert property (step_led == (8'h01 << step_idx))
    else $error("step lamp wrong");
  a_reset_holds: assert property (clr |=> step_idx == 3'h0)
    else $error("reset not held");
  a_idle_keeps: assert property (!running && !btn_step && !clr |=> $stable(step_idx))
    else $error("idle step moved");
  a_clock_adv: assert property (running && $rose(jack_step) && !btn_step && !clr
    |=> step_idx == $past(step_idx) + 3'h1) else $error("advance wrong");
  a_rows_follow: assert property (held |-> {gate_out, row_led} ==
    {lo == 2'h2, lo == 2'h2, lo == 2'h1, up == 2'h2, up == 2'h1}) else $error("rows wrong");
  a_start_runs: assert property ($rose(btn_start | jack_start) && !running |=> running)
    else $error("start ignored");
  a_stop_halts: assert property ($rose(btn_stop | jack_stop) && running |=> !running)
    else $error("stop ignored");
  a_slew_select: assert property (1 |=> slew_en == !$past(slew_ctrl & slew_ctrl_present))
    else $error("slew wrong");
  a_trig_routes: assert property ($changed(step_idx) && $stable(sel_upper) && $stable(sel_lower)
    |-> trig_out == {lo == 2'h1, up == 2'h2, up == 2'h1}) else $error("trigger rows wrong");
endmodule
bind ets_sequencer ets_seq_asserts #(.NUM_STEPS(NUM_STEPS)) u_chk (.*);

//--- verification/ets_clock_src.sv
`timescale 1ns/1ps
module ets_clock_src (
  input wire clock, // bench clock
  input wire fire, // request one step clock
  output reg jack_step // step clock socket
);
  initial jack_step = 1'b0;
  // low between pulses so every request is a fresh edge
  always @(posedge clock) jack_step <= fire;
endmodule

//--- verification/eight_step_trigger_sequencer_tb_top.sv
`timescale 1ns/1ps
module eight_step_trigger_sequencer_tb_top;
  reg clock = 1'b0, rst = 1'b1, fire = 1'b0, slew_ctrl = 1'b0, slew_ctrl_present = 1'b0;
  reg [6:0] ctl = 7'h00;
  reg [15:0] sel_upper = 16'h0000, sel_lower = 16'h0000;
  wire btn_start, btn_stop, btn_step, btn_reset, jack_start, jack_stop, jack_reset, jack_step;
  wire gate_out, slew_en, running;
  wire [7:0] step_led;
  wire [2:0] trig_out, step_idx;
  wire [3:0] row_led;
  integer failures = 0, checks_done = 0, i;
  reg [7:0] tbl [0:3];
  assign {btn_start, btn_stop, btn_step, btn_reset, jack_start, jack_stop, jack_reset} = ctl;
  always #4 clock = ~clock;
  ets_clock_src u_src (.clock(clock), .fire(fire), .jack_step(jack_step));
  ets_sequencer #(.TRIG_PULSE_NS(80)) DUT (.*);
  task cmp(input [7:0] got, input [7:0] exp);
    begin
      #1 checks_done = checks_done + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  task hit(input [6:0] m, input integer n);
    begin ctl <= m; tick(n); ctl <= 7'h00; tick(3); end
  endtask
  task clk;
    begin fire <= 1'b1; tick(1); fire <= 1'b0; tick(3); end
  endtask
  task conclude;
    begin
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    tbl[0] = 8'h41; tbl[1] = 8'h96; tbl[2] = 8'h28; tbl[3] = 8'hF0;
    tick(5); rst <= 1'b0; tick(1);
    // rows: upper code, lower code, expected row lamps
    for (i = 0; i < 4; i = i + 1) begin
      sel_upper <= {8{tbl[i][7:6]}}; sel_lower <= {8{tbl[i][5:4]}}; tick(3);
      cmp(row_led, tbl[i][3:0]);
      cmp(gate_out, tbl[i][3]);
    end
    cmp(step_led, 8'h01);
    sel_upper <= 16'h5555;
    hit(7'h10, 4); cmp(step_idx, 3'h1);
    cmp(trig_out, 3'h1);
    tick(10); cmp(trig_out, 3'h0);
    for (i = 0; i < 8; i = i + 1) hit(7'h10, 1);
    cmp(step_idx, 3'h1);
    clk; cmp(step_idx, 3'h1);
    hit(7'h04, 6); cmp(running, 1'b1);
    clk; clk; cmp(step_led, 8'h08);
    hit(7'h20, 1); cmp(running, 1'b0);
    clk; cmp(step_idx, 3'h3);
    hit(7'h01, 3); cmp(step_idx, 3'h0);
    hit(7'h10, 1); cmp(step_idx, 3'h1);
    slew_ctrl <= 1'b1; tick(2); cmp(slew_en, 1'b1);
    slew_ctrl_present <= 1'b1; tick(2); cmp(slew_en, 1'b0);
    // second reset while stopped brings the step back to one
    rst <= 1'b1; tick(1); rst <= 1'b0; tick(2);
    cmp(step_led, 8'h01);
    cmp(running, 1'b0);
    conclude;
  end
  initial begin
    #40000 failures = failures + 1;
    conclude;
  end
endmodule
